/* inc/rvt_pkg.sv */
`default_nettype none
package rvt_pkg;

   // Clock and time base
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_TIME_US  = 2000;
   localparam int TICK_CYCLES   = (TICK_TIME_US * 1000) / CLK_PERIOD_NS;

   // Indication delay unit and code range
   localparam int DELAY_UNIT_MS    = 256;
   localparam int DELAY_UNIT_TICKS = (DELAY_UNIT_MS * 1000) / TICK_TIME_US;
   localparam int DELAY_CODE_W     = 3;
   localparam int DELAY_TICK_W     = 10;

   // Qualification timer width
   localparam int QUAL_W = 6;

   // Reset values and decrement steps
   localparam logic [QUAL_W-1:0]       QUAL_RESET  = 6'h00;
   localparam logic [DELAY_TICK_W-1:0] DELAY_ZERO  = 10'h000;
   localparam logic [DELAY_TICK_W-1:0] DELAY_ONE   = 10'h001;
   localparam logic [QUAL_W-1:0]       QUAL_ONE    = 6'h01;

   typedef struct packed {
      logic [DELAY_CODE_W-1:0] ring_indication_delay;
      logic [QUAL_W-1:0]       ring_high_freq_threshold;
      logic [QUAL_W-1:0]       qualLoad;
   } rvt_cfg_s;

   typedef struct packed {
      logic              ringTooFast;
      logic              ringAccepted;
      logic [QUAL_W-1:0] qualTimer;
   } rvt_qual_s;

   typedef enum logic [1:0] {
      IND_IDLE,
      IND_WAIT,
      IND_ON
   } rvt_ind_e;

endpackage
`default_nettype wire

/* hw/rvt_tick_gen.sv */
`timescale 1ns/1ns
`default_nettype none
module rvt_tick_gen #(
   parameter int TICK_CYCLES = rvt_pkg::TICK_CYCLES
) (
   input  wire logic mclk,
   input  wire logic reset_n,
   output var  logic tick
);
   localparam int CW = $clog2(TICK_CYCLES);
   localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);
   localparam logic [CW-1:0] ZERO = CW'(0);
   localparam logic [CW-1:0] ONE  = CW'(1);

   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   logic          next_tick;

   always_comb begin
      next_count = count + ONE;
      next_tick  = 1'b0;
      if (count == LAST) begin
         next_count = ZERO;
         next_tick  = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         count <= ZERO;
         tick  <= 1'b0;
      end else begin
         count <= next_count;
         tick  <= next_tick;
      end
   end
endmodule
`default_nettype wire

/* hw/rvt_ring_timing.sv */
`timescale 1ns/1ns
`default_nettype none
module rvt_ring_timing #(
   parameter int TICK_CYCLES = rvt_pkg::TICK_CYCLES
) (
   input  wire logic                                mclk,
   input  wire logic                                reset_n,
   input  wire rvt_pkg::rvt_cfg_s                   cfg,
   input  wire logic                                ringEvent,
   input  wire logic                                ringValidated,
   output var  rvt_pkg::rvt_qual_s                  qual,
   output var  logic                                ringIndicate,
   output var  logic                                delayBusy,
   output var  logic [rvt_pkg::DELAY_TICK_W-1:0]    delayRemain
);
   localparam int QW = rvt_pkg::QUAL_W;
   localparam int DW = rvt_pkg::DELAY_TICK_W;

   // Limits: threshold above load never rejects
   // Free-running tick: timer and delay up to one tick short
   // Event and tick together: event wins, tick dropped
   // New delay needs one idle cycle after indication drops

   logic tick;

   // One shared 2 ms time base for both timers
   rvt_tick_gen #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .mclk    (mclk),
      .reset_n (reset_n),
      .tick    (tick)
   );

   // Delay code to tick count, linear in 256 ms steps
   function automatic logic [DW-1:0] delay_ticks(
      input logic [rvt_pkg::DELAY_CODE_W-1:0] code
   );
      delay_ticks = DW'(int'(code) * rvt_pkg::DELAY_UNIT_TICKS);
   endfunction

   // Ring frequency qualification
   logic [QW-1:0] qualTimer;
   logic [QW-1:0] next_qualTimer;
   logic          tooFast;
   logic          next_tooFast;
   logic          accepted;
   logic          next_accepted;

   function automatic logic over_threshold(
      input logic [QW-1:0] timer,
      input logic [QW-1:0] threshold
   );
      over_threshold = (timer > threshold);
   endfunction

   function automatic logic [QW-1:0] timer_less_one(
      input logic [QW-1:0] timer
   );
      timer_less_one = rvt_pkg::QUAL_RESET;
      if (timer != rvt_pkg::QUAL_RESET) begin
         timer_less_one = timer - rvt_pkg::QUAL_ONE;
      end
   endfunction

   // Output carrier for the qualification result
   function automatic rvt_pkg::rvt_qual_s pack_qual(
      input logic [QW-1:0] timer,
      input logic          fast,
      input logic          ok
   );
      pack_qual.qualTimer    = timer;
      pack_qual.ringTooFast  = fast;
      pack_qual.ringAccepted = ok;
   endfunction

   always_comb begin
      next_qualTimer = qualTimer;
      next_tooFast   = 1'b0;
      next_accepted  = 1'b0;
      if (ringEvent) begin
         if (over_threshold(qualTimer, cfg.ring_high_freq_threshold)) begin
            next_tooFast = 1'b1;
         end else begin
            next_accepted = 1'b1;
         end
         // reload on event
         // Reload comes after the compare, which sees the old value
         next_qualTimer = cfg.qualLoad;
      end else if (tick) begin
         next_qualTimer = timer_less_one(qualTimer);
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         // Timer starts at zero, so the first ring is accepted
         qualTimer <= rvt_pkg::QUAL_RESET;
         tooFast   <= 1'b0;
         accepted  <= 1'b0;
      end else begin
         qualTimer <= next_qualTimer;
         tooFast   <= next_tooFast;
         accepted  <= next_accepted;
      end
   end

   always_comb begin
      qual = pack_qual(qualTimer, tooFast, accepted);
   end

   // Indication delay
   rvt_pkg::rvt_ind_e indState;
   rvt_pkg::rvt_ind_e next_indState;
   logic [DW-1:0]     delayCount;
   logic [DW-1:0]     next_delayCount;
   logic [DW-1:0]     delayLoad;
   logic              next_ringIndicate;
   logic              next_delayBusy;

   // State decode shared by the ringIndicate and delayBusy output flags
   function automatic logic in_state(
      input rvt_pkg::rvt_ind_e state,
      input rvt_pkg::rvt_ind_e wanted
   );
      in_state = (state == wanted);
   endfunction

   function automatic logic [DW-1:0] delay_less_one(
      input logic [DW-1:0] count
   );
      delay_less_one = rvt_pkg::DELAY_ZERO;
      if (count != rvt_pkg::DELAY_ZERO) begin
         delay_less_one = count - rvt_pkg::DELAY_ONE;
      end
   endfunction

   always_comb begin
      next_indState   = indState;
      next_delayCount = delayCount;
      delayLoad       = delay_ticks(cfg.ring_indication_delay);
      case (indState)
         rvt_pkg::IND_IDLE: begin
            if (ringValidated) begin
               next_delayCount = delayLoad;
               // Code zero goes straight to the indication
               if (delayLoad == rvt_pkg::DELAY_ZERO) begin
                  next_indState = rvt_pkg::IND_ON;
               end else begin
                  next_indState = rvt_pkg::IND_WAIT;
               end
            end
         end
         rvt_pkg::IND_WAIT: begin
            // Validation lost during delay cancels the indication
            if (!ringValidated) begin
               next_indState   = rvt_pkg::IND_IDLE;
               next_delayCount = rvt_pkg::DELAY_ZERO;
            end else if (tick) begin
               next_delayCount = delay_less_one(delayCount);
               if (delayCount == rvt_pkg::DELAY_ONE) begin
                  next_indState = rvt_pkg::IND_ON;
               end
            end
         end
         rvt_pkg::IND_ON: begin
            // Indication stands as long as validation does
            next_delayCount = rvt_pkg::DELAY_ZERO;
            if (!ringValidated) begin
               next_indState = rvt_pkg::IND_IDLE;
            end
         end
         default: begin
            next_indState   = rvt_pkg::IND_IDLE;
            next_delayCount = rvt_pkg::DELAY_ZERO;
         end
      endcase
      next_ringIndicate = in_state(next_indState, rvt_pkg::IND_ON);
      next_delayBusy    = in_state(next_indState, rvt_pkg::IND_WAIT);
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         indState     <= rvt_pkg::IND_IDLE;
         delayCount   <= rvt_pkg::DELAY_ZERO;
         ringIndicate <= 1'b0;
         delayBusy    <= 1'b0;
      end else begin
         indState     <= next_indState;
         delayCount   <= next_delayCount;
         ringIndicate <= next_ringIndicate;
         delayBusy    <= next_delayBusy;
      end
   end

   always_comb begin
      delayRemain = delayCount;
   end
endmodule
`default_nettype wire

/* test/rvt_ring_timing_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module rvt_ring_timing_asserts #(
   parameter int TICK_CYCLES = 4
) (
   input wire logic                             mclk,
   input wire logic                             reset_n,
   input wire rvt_pkg::rvt_cfg_s                cfg,
   input wire logic                             ringEvent,
   input wire logic                             ringValidated,
   input wire rvt_pkg::rvt_qual_s               qual,
   input wire logic                             ringIndicate,
   input wire logic                             delayBusy,
   input wire logic [rvt_pkg::DELAY_TICK_W-1:0] delayRemain
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // Idle means neither counting nor indicating
   sequence s_idleVal;
      !ringIndicate && !delayBusy && ringValidated;
   endsequence
   load_on_event_a: assert property (ringEvent |=> qual.qualTimer == $past(cfg.qualLoad))
      else $error("timer not loaded");
   too_fast_a: assert property (ringEvent && qual.qualTimer > cfg.ring_high_freq_threshold
      |=> qual.ringTooFast && !qual.ringAccepted) else $error("fast ring kept");
   accept_ring_a: assert property (ringEvent && qual.qualTimer <= cfg.ring_high_freq_threshold
      |=> qual.ringAccepted && !qual.ringTooFast) else $error("slow ring refused");
   pulse_cause_a: assert property (qual.ringTooFast || qual.ringAccepted |-> $past(ringEvent))
      else $error("verdict without event");
   no_wrap_a: assert property (!ringEvent && qual.qualTimer == 6'h00 |=> qual.qualTimer == 6'h00)
      else $error("timer wrapped");
   count_down_a: assert property (!ringEvent |=> qual.qualTimer == $past(qual.qualTimer)
      || qual.qualTimer == $past(qual.qualTimer) - 6'h01) else $error("timer jumped");
   zero_delay_a: assert property (s_idleVal ##0 cfg.ring_indication_delay == 3'h0
      |=> ringIndicate) else $error("no prompt indication");
   delay_load_a: assert property (s_idleVal ##0 cfg.ring_indication_delay != 3'h0
      |=> delayBusy && delayRemain == {$past(cfg.ring_indication_delay), 7'h00})
      else $error("delay not loaded");
   // Validation gone while counting or indicating
   sequence s_lostVal;
      !ringValidated && (delayBusy || ringIndicate);
   endsequence
   cancel_drop_a: assert property (s_lostVal |=> !delayBusy && !ringIndicate
      && delayRemain == 10'h000) else $error("indication kept");
   delay_step_a: assert property (delayBusy && ringValidated |=> delayRemain == $past(delayRemain)
      || delayRemain == $past(delayRemain) - 10'h001) else $error("delay jumped");
endmodule
bind rvt_ring_timing rvt_ring_timing_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk_inst (
   .mclk(mclk), .reset_n(reset_n), .cfg(cfg), .ringEvent(ringEvent),
   .ringValidated(ringValidated), .qual(qual), .ringIndicate(ringIndicate),
   .delayBusy(delayBusy), .delayRemain(delayRemain));
`default_nettype wire

/* test/tb_rvt_ring_timing.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
   $display("[FAIL] %0t %h %h", $time, a, b); end end
module tb_rvt_ring_timing;
   logic               mclk = 1'b0;
   logic               reset_n = 1'b0;
   rvt_pkg::rvt_cfg_s  cfg = '0;
   logic               ringEvent = 1'b0;
   logic               ringValidated = 1'b0;
   rvt_pkg::rvt_qual_s qual;
   logic               ringIndicate;
   logic               delayBusy;
   logic [9:0]         delayRemain;
   int                 mismatches = 0;
   int                 tests_run = 0;
   int                 n;
   rvt_ring_timing #(.TICK_CYCLES(4)) rvt_ring_timing_inst (.mclk(mclk), .reset_n(reset_n),
      .cfg(cfg), .ringEvent(ringEvent), .ringValidated(ringValidated), .qual(qual),
      .ringIndicate(ringIndicate), .delayBusy(delayBusy), .delayRemain(delayRemain));
   initial forever #5 mclk = ~mclk;
   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic ring(input logic tooFast);
      @(posedge mclk) ringEvent <= 1'b1;
      @(posedge mclk) ringEvent <= 1'b0;
      #1 `CHK(qual.ringTooFast, tooFast)
      `CHK(qual.ringAccepted, ~tooFast)
      `CHK(qual.qualTimer, cfg.qualLoad)
   endtask
   task automatic t_qual;
      @(posedge mclk) cfg.qualLoad <= 6'h14;
      cfg.ring_high_freq_threshold <= 6'h0b;
      ring(1'b0);
      ring(1'b1);
      repeat (60) @(posedge mclk);
      ring(1'b0);
      repeat (120) @(posedge mclk);
      #1 `CHK(qual.qualTimer, 6'h00)
   endtask
   task automatic t_delay(input logic [2:0] code);
      @(posedge mclk) cfg.ring_indication_delay <= code;
      @(posedge mclk) ringValidated <= 1'b1;
      @(posedge mclk) #1;
      `CHK(delayRemain, {code, 7'h00})
      `CHK(ringIndicate, code == 3'h0)
      `CHK(delayBusy, code != 3'h0)
      n = 0;
      while (!ringIndicate && n < 4000) begin
         @(posedge mclk) #1;
         n++;
      end
      // Free-running tick costs up to one tick of phase
      `CHK(n + 3 >= code * 512 && n <= code * 512 + 2, 1'b1)
      @(posedge mclk) ringValidated <= 1'b0;
      repeat (2) @(posedge mclk) #1;
      `CHK(ringIndicate, 1'b0)
   endtask
   task automatic t_cancel;
      @(posedge mclk) cfg.ring_indication_delay <= 3'h2;
      @(posedge mclk) ringValidated <= 1'b1;
      repeat (20) @(posedge mclk);
      #1 `CHK(delayBusy, 1'b1)
      @(posedge mclk) ringValidated <= 1'b0;
      @(posedge mclk) #1;
      `CHK({delayBusy, delayRemain}, 11'h000)
      `CHK(ringIndicate, 1'b0)
   endtask
   initial begin
      repeat (16) @(posedge mclk);
      reset_n <= 1'b1;
      t_qual();
      for (int c = 0; c < 8; c++) t_delay(3'(c));
      t_cancel();
      finish_test();
   end
   initial begin
      #400000;
      mismatches++;
      finish_test();
   end
endmodule
`default_nettype wire
